// >>> core/sram_host_pkg.sv
// Package: timing constants and state type for the latched-address static RAM host controller
//
// How it works
// - Read: select low, strobe high, data after access
// - Early select: strobe disables device, wait data delay
// - Select inside strobe: device never drives bus
// - Inside-strobe write: data timed to select rise
// - Select and strobe low store bus data
// - Strobe may stay low across consecutive writes
// - Space select falling edges by cycle time
// - Hold select high for deselect width
// - Hold select low for select width
// - Hold strobe low for strobe width
// - Select stays high during data retention; code only holds off new requests, a cycle already taken still selects
// - Wait one deselect width after supply returns
// - Only one bank selected, gap before next
`default_nettype none

package sram_host_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and memory timing figures, in nanoseconds
    localparam int CLK_PERIOD_NS = 50;
    localparam int SELECT_ACCESS_TIME_NS = 350;
    localparam int SELECT_MIN_WIDTH_NS = 350;
    localparam int DESELECT_MIN_WIDTH_NS = 150;
    localparam int CYCLE_MIN_TIME_NS = 500;
    localparam int STROBE_MIN_WIDTH_NS = 350;
    localparam int SELECT_DISABLE_TIME_NS = 180;
    localparam int DATA_SETUP_TIME_NS = 170;
    localparam int EARLY_HIZ_TIME_NS = 0;
    localparam int LATE_HIZ_TIME_NS = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Least times rounded up to whole clock cycles
    localparam int ACCESS_CYC = (SELECT_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SELW_CYC = (SELECT_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRW_CYC = (STROBE_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC = (DATA_SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DESEL_CYC = (DESELECT_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_CYC = (CYCLE_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TURN_CYC = (SELECT_DISABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Select low phase is the longer of the access time and the select width
    localparam int SEL_CYC = (ACCESS_CYC > SELW_CYC) ? ACCESS_CYC : SELW_CYC;
    // After a read the gap also covers the device driver turn-off
    localparam int GAP_RD_CYC = (TURN_CYC > DESEL_CYC) ? TURN_CYC : DESEL_CYC;

    // Width of the down counters
    localparam int CNT_W = 5;

    ////////////////////////////////////////////////////////////////////////////////
    // Controller states
    typedef enum logic [2:0] {
        ST_POWER,
        ST_IDLE,
        ST_ADDR,
        ST_SEL,
        ST_RISE,
        ST_GAP
    } state_t;

endpackage

`default_nettype wire

// >>> core/sram_host_timer.sv
// Down counter that reports when a loaded interval has run out
`timescale 1ns/100ps
`default_nettype none

module sram_host_timer #(
    parameter int W = 5
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Control
    input wire logic load,
    input wire logic [W-1:0] value,
    // Status
    output logic done
);

    logic [W-1:0] count_q;
    logic [W-1:0] count_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Load wins over the decrement; the count rests at zero
    assign count_d = load ? value : ((count_q != '0) ? count_q - W'(1) : count_q);
    assign done = (count_q == '0);

    // Count register
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            count_q <= '0;
        else
            count_q <= count_d;
    end

endmodule

`default_nettype wire

// >>> core/sram_host_ctrl.sv
// Host controller that runs read and write cycles on a latched-address static RAM
`timescale 1ns/100ps
`default_nettype none

module sram_host_ctrl #(
    parameter int ADDR_W = 13,
    parameter int DATA_W = 4,
    parameter int BANKS = 2,
    parameter int BANK_W = (BANKS > 1) ? $clog2(BANKS) : 1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Supply and retention status
    input wire logic supply_ok,
    input wire logic retain,
    // Request from the user
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [BANK_W-1:0] req_bank,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic req_ready,
    // Answers to the user
    output logic rd_valid,
    output logic [DATA_W-1:0] rd_data,
    output logic wr_done,
    // Memory pins
    output logic [BANKS-1:0] mem_ce_n,
    output logic mem_we_n,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [DATA_W-1:0] mem_dq_out,
    output logic mem_dq_oe_n,
    input wire logic [DATA_W-1:0] mem_dq_in
);

    import sram_host_pkg::*;

    state_t state_q;
    state_t state_d;
    logic wr_q;
    logic [BANK_W-1:0] bank_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] rdata_q;
    logic rd_valid_q;
    logic wr_done_q;
    logic [BANKS-1:0] ce_n_q;
    logic we_n_q;
    logic oe_n_q;
    logic ph_load;
    logic [CNT_W-1:0] ph_val;
    logic ph_done;
    logic cyc_load;
    logic cyc_done;
    logic req_fire;
    logic sel_phase_end;
    logic sel_on_d;
    logic wr_phase_d;
    logic stream_wr;
    logic we_low_d;
    logic oe_low_d;
    logic boot_q;
    logic wr_next;

    ////////////////////////////////////////////////////////////////////////////////
    // Timers: one for the phase in hand, one for the spacing of select falls
    sram_host_timer #(
        .W(CNT_W)
    ) u_phase (
        .mclk(mclk),
        .reset_n(reset_n),
        .load(ph_load),
        .value(ph_val),
        .done(ph_done)
    );

    sram_host_timer #(
        .W(CNT_W)
    ) u_cycle (
        .mclk(mclk),
        .reset_n(reset_n),
        .load(cyc_load),
        .value(CNT_W'(CYC_CYC - 1)),
        .done(cyc_done)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Request acceptance; no new cycle while retaining or without supply
    assign req_ready = (state_q == ST_IDLE) && supply_ok && !retain && cyc_done;
    assign req_fire = req_ready && req_valid;
    assign sel_phase_end = (state_q == ST_SEL) && ph_done;

    // Next state and timer loads
    always_comb
    begin
        state_d = state_q;
        ph_load = 1'b0;
        ph_val = '0;
        cyc_load = 1'b0;
        unique case (state_q)
            ST_POWER:
            begin
                // Hold off for one deselect width once the supply is good, after reset as well
                if (!supply_ok || boot_q)
                begin
                    ph_load = 1'b1;
                    ph_val = CNT_W'(DESEL_CYC - 1);
                end
                else if (ph_done)
                    state_d = ST_IDLE;
            end
            ST_IDLE:
            begin
                if (!supply_ok)
                begin
                    state_d = ST_POWER;
                    ph_load = 1'b1;
                    ph_val = CNT_W'(DESEL_CYC - 1);
                end
                else if (req_fire)
                    state_d = ST_ADDR;
            end
            ST_ADDR:
            begin
                // Address set up one cycle ahead; select falls on the next edge
                state_d = ST_SEL;
                ph_load = 1'b1;
                ph_val = CNT_W'(SEL_CYC - 1);
                cyc_load = 1'b1;
            end
            ST_SEL:
            begin
                if (ph_done)
                    state_d = ST_RISE;
            end
            ST_RISE:
            begin
                // A read leaves time for the device drivers to switch off
                state_d = ST_GAP;
                ph_load = 1'b1;
                ph_val = wr_q ? CNT_W'(DESEL_CYC - 1) : CNT_W'(GAP_RD_CYC - 1);
            end
            ST_GAP:
            begin
                if (ph_done)
                    state_d = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin levels for the coming cycle
    // Writes keep the select inside the strobe so the device never drives the bus
    assign sel_on_d = (state_d == ST_SEL);
    // The request being taken counts already, so the strobe leads the select by a cycle
    assign wr_next = req_fire ? req_write : wr_q;
    assign wr_phase_d = wr_next && ((state_d == ST_ADDR) || (state_d == ST_SEL) || (state_d == ST_RISE));
    // A following write lets the strobe stay low between selects
    assign stream_wr = wr_q && req_valid && req_write && !retain && supply_ok
        && ((state_d == ST_GAP) || (state_d == ST_IDLE));
    assign we_low_d = wr_phase_d || stream_wr;
    assign oe_low_d = wr_phase_d;

    ////////////////////////////////////////////////////////////////////////////////
    // State and request latches
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= ST_POWER;
            boot_q <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            boot_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_q <= 1'b0;
            bank_q <= '0;
            addr_q <= '0;
            wdata_q <= '0;
        end
        else if (req_fire)
        begin
            wr_q <= req_write;
            bank_q <= req_bank;
            addr_q <= req_addr;
            wdata_q <= req_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One select line per bank; at most one is low at any time
    genvar b;
    generate
        for (b = 0; b < BANKS; b++)
        begin : g_sel
            always_ff @(posedge mclk or negedge reset_n)
            begin
                if (!reset_n)
                    ce_n_q[b] <= 1'b1;
                else
                    ce_n_q[b] <= !(sel_on_d && (bank_q == BANK_W'(b)));
            end
        end
    endgenerate

    // Strobe and data drive registers
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            we_n_q <= 1'b1;
            oe_n_q <= 1'b1;
        end
        else
        begin
            we_n_q <= !we_low_d;
            oe_n_q <= !oe_low_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read capture at the access time; select is still low on this edge
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdata_q <= '0;
            rd_valid_q <= 1'b0;
            wr_done_q <= 1'b0;
        end
        else
        begin
            if (sel_phase_end && !wr_q)
                rdata_q <= mem_dq_in;
            rd_valid_q <= sel_phase_end && !wr_q;
            wr_done_q <= sel_phase_end && wr_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Port drives, all from flip-flops
    assign mem_ce_n = ce_n_q;
    assign mem_we_n = we_n_q;
    assign mem_addr = addr_q;
    assign mem_dq_out = wdata_q;
    assign mem_dq_oe_n = oe_n_q;
    assign rd_data = rdata_q;
    assign rd_valid = rd_valid_q;
    assign wr_done = wr_done_q;

endmodule

`default_nettype wire

// >>> test/sram_host_ctrl_props.sv
// Checker for the memory pin timing of the static RAM host controller
`timescale 1ns/100ps
`default_nettype none

module sram_host_ctrl_props #(
    parameter int ADDR_W = 13,
    parameter int DATA_W = 4,
    parameter int BANKS = 2
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Status and answers
    input wire logic retain,
    input wire logic rd_valid,
    input wire logic wr_done,
    // Memory pins
    input wire logic [BANKS-1:0] mem_ce_n,
    input wire logic mem_we_n,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [DATA_W-1:0] mem_dq_out,
    input wire logic mem_dq_oe_n
);
    wire logic sel_n = &mem_ce_n;
    logic [4:0] since_q;
    logic sel_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Cycles since the last select fall; saturates so a long idle never wraps
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            since_q <= 5'h1F;
            sel_q <= 1'b1;
        end
        else
        begin
            sel_q <= sel_n;
            since_q <= (sel_q && !sel_n) ? 5'h01 : (since_q == 5'h1F ? since_q : since_q + 5'h01);
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin relations
    a_one_select: assert property ($onehot0(~mem_ce_n)) else $error("two selects low");
    a_sel_width: assert property ($fell(sel_n) |-> !sel_n[*7] ##1 sel_n) else $error("select width");
    a_desel_width: assert property ($rose(sel_n) |-> sel_n[*3]) else $error("deselect width");
    a_cycle_spacing: assert property ($fell(sel_n) |-> since_q >= 5'h0A) else $error("cycle spacing");
    a_strobe_leads: assert property ($fell(sel_n) |-> mem_we_n == $past(mem_we_n)) else $error("strobe lead");
    a_strobe_trails: assert property ($rose(sel_n) |-> mem_we_n == $past(mem_we_n)) else $error("strobe trail");
    a_addr_held: assert property (!sel_n |-> $stable(mem_addr)) else $error("address moved");
    a_write_data: assert property (!sel_n && !mem_we_n |-> !mem_dq_oe_n && $stable(mem_dq_out))
        else $error("write data");
    a_read_turnoff: assert property ($rose(sel_n) && mem_we_n |-> mem_dq_oe_n[*4]) else $error("turnoff");
    a_read_answer: assert property ($rose(sel_n) && mem_we_n |-> ##[0:1] rd_valid) else $error("no rd_valid");
    a_write_answer: assert property ($rose(sel_n) && !mem_we_n |-> ##[0:1] wr_done) else $error("no wr_done");
    a_retain_idle: assert property (retain[*3] ##0 sel_n |=> sel_n) else $error("select in retention");
endmodule

bind sram_host_ctrl sram_host_ctrl_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .BANKS(BANKS)) u_props (
    .mclk(mclk), .reset_n(reset_n), .retain(retain), .rd_valid(rd_valid), .wr_done(wr_done),
    .mem_ce_n(mem_ce_n), .mem_we_n(mem_we_n), .mem_addr(mem_addr), .mem_dq_out(mem_dq_out),
    .mem_dq_oe_n(mem_dq_oe_n));

`default_nettype wire

// >>> test/sram_dev_model.sv
// Behavioural model of the latched-address static RAM
`timescale 1ns/100ps
`default_nettype none

module sram_dev_model #(
    parameter int ADDR_W = 13,
    parameter int DATA_W = 4,
    parameter int BANKS = 2,
    // Just inside the access time, so the host's sampling edge meets the worst case without a race
    parameter int ACC_NS = 340
) (
    // Memory pins
    input wire logic [BANKS-1:0] mem_ce_n,
    input wire logic mem_we_n,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [DATA_W-1:0] dq_bus,
    // Device drive onto the shared bus
    output logic [DATA_W-1:0] dev_q,
    output logic dev_oe
);
    logic [DATA_W-1:0] mem_q [BANKS][2**ADDR_W];
    int bank_q;
    logic [ADDR_W-1:0] addr_q;
    wire logic sel_n = &mem_ce_n;

    // No clock: select fall latches the address, later changes are ignored
    always @(negedge sel_n)
    begin
        for (int b = 0; b < BANKS; b++)
            if (!mem_ce_n[b])
                bank_q = b;
        addr_q = mem_addr;
        dev_q = ~dq_bus; // Garbage until access time has run
        #ACC_NS;
        if (!sel_n)
            dev_q = mem_q[bank_q][addr_q];
    end

    // Drivers only with select low and strobe high, off at once otherwise
    assign dev_oe = !sel_n && mem_we_n;

    // Select inside strobe: data taken at the select rising edge
    always @(posedge sel_n)
        if (!mem_we_n)
            mem_q[bank_q][addr_q] = dq_bus;
endmodule

`default_nettype wire

// >>> test/test_latched_addr_static_ram_port.sv
// Testbench for the static RAM host controller with a device model
`timescale 1ns/100ps
`default_nettype none

module test_latched_addr_static_ram_port;
    import sram_host_pkg::*;
    logic mclk = 0, reset_n = 0, supply_ok = 1, retain = 0, req_valid = 0, req_write = 0;
    logic [0:0] req_bank = 0;
    logic [12:0] req_addr = 0;
    logic [3:0] req_wdata = 0;
    logic req_ready, rd_valid, wr_done, mem_we_n, mem_dq_oe_n, dev_oe;
    logic [3:0] rd_data, mem_dq_out, dev_q;
    logic [1:0] mem_ce_n;
    logic [12:0] mem_addr;
    wire logic [3:0] dq_bus;
    wire logic sel_n = &mem_ce_n;
    int n_mismatch = 0, total_checks = 0, falls = 0, we_rise = 0, n_wr = 0;
    logic [3:0] rq[$];

    always #25 mclk = ~mclk;

    sram_host_ctrl u_dut (.mclk(mclk), .reset_n(reset_n), .supply_ok(supply_ok), .retain(retain),
        .req_valid(req_valid), .req_write(req_write), .req_bank(req_bank), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
        .wr_done(wr_done), .mem_ce_n(mem_ce_n), .mem_we_n(mem_we_n), .mem_addr(mem_addr),
        .mem_dq_out(mem_dq_out), .mem_dq_oe_n(mem_dq_oe_n), .mem_dq_in(dq_bus));
    sram_dev_model u_mem (.mem_ce_n(mem_ce_n), .mem_we_n(mem_we_n), .mem_addr(mem_addr),
        .dq_bus(dq_bus), .dev_q(dev_q), .dev_oe(dev_oe));

    ////////////////////////////////////////////////////////////////////////////////
    // Bus level; a released bus shows the inverse so stale data never passes
    assign dq_bus = !mem_dq_oe_n ? mem_dq_out : (dev_oe ? dev_q : ~mem_dq_out);

    // Monitors of answers and pin edges
    always @(posedge mclk)
    begin
        if (rd_valid === 1'b1)
            rq.push_back(rd_data);
        if (wr_done === 1'b1)
            n_wr++;
    end
    always @(negedge sel_n)
        falls++;
    always @(posedge mem_we_n)
        we_rise++;
    always @(negedge mclk)
        if (!mem_dq_oe_n && dev_oe)
            chk("bus_clash", 1, 0);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task final_report;
        if (n_mismatch == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Present a request and hold it until the edge that takes it
    task issue(input logic w, input logic [12:0] a, input logic [3:0] d, input logic b);
        int i;
        @(negedge mclk);
        req_write = w;
        req_bank = b;
        req_addr = a;
        req_wdata = d;
        req_valid = 1'b1;
        for (i = 0; i < 60 && req_ready !== 1'b1; i++)
            @(negedge mclk);
        if (i == 60)
        begin
            n_mismatch++;
            final_report;
        end
        @(posedge mclk);
    endtask

    task idle(input int n);
        @(negedge mclk);
        req_valid = 1'b0;
        repeat (n) @(negedge mclk);
    endtask

    task pop_chk(input string n, input logic [3:0] e);
        chk(n, rq.size() > 0 ? rq.pop_front() : 4'hX, e);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Three writes back to back: strobe stays low between them
    task automatic t_write_burst;
        int r0 = we_rise;
        int w0 = n_wr;
        issue(1'b1, 13'h0000, 4'hA, 1'b0);
        issue(1'b1, 13'h1FFF, 4'h5, 1'b1);
        issue(1'b1, 13'h1FFF, 4'h3, 1'b0);
        idle(20);
        chk("wr_done_count", n_wr - w0, 3);
        chk("strobe_rises", we_rise - r0, 1);
    endtask

    // Reads back to back at both banks and address ends
    task t_read_back;
        issue(1'b0, 13'h0000, 4'h0, 1'b0);
        issue(1'b0, 13'h1FFF, 4'h0, 1'b1);
        issue(1'b0, 13'h1FFF, 4'h0, 1'b0);
        idle(20);
        pop_chk("rd0", 4'hA);
        pop_chk("rd1", 4'h5);
        pop_chk("rd2", 4'h3);
    endtask

    // Retention holds a waiting request off, release lets that same request through
    task automatic t_retain;
        int f0 = falls;
        @(negedge mclk);
        retain = 1'b1;
        req_write = 1'b0;
        req_addr = 13'h0000;
        req_valid = 1'b1;
        repeat (30) @(negedge mclk);
        chk("retain_falls", falls - f0, 0);
        retain = 1'b0;
        idle(20);
        pop_chk("rd_after_retain", 4'hA);
    endtask

    // Supply loss: first select fall waits a deselect width after return
    task t_power;
        int c = 0;
        int f0;
        @(negedge mclk);
        supply_ok = 1'b0;
        repeat (4) @(negedge mclk);
        f0 = falls;
        supply_ok = 1'b1;
        req_write = 1'b1;
        req_valid = 1'b1;
        while (falls == f0 && c < 40)
        begin
            @(negedge mclk);
            c++;
        end
        chk("power_wait", c > DESEL_CYC && c < 40, 1);
        idle(20);
    endtask

    initial
    begin
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
        t_write_burst;
        t_read_back;
        t_retain;
        t_power;
        final_report;
    end
endmodule

`default_nettype wire
